// ---- hdl/aeu_core.sv ----
// Purpose: execution slice for add/and literal and add/and file instructions
// Assumes: one instruction per clock when instr_valid_i is high; file data
//          for instr_i[6:0] is presented combinationally on file_rdata_i
// Notes:   other opcodes are ignored and leave acc and the flags unchanged;
//          file write-back is registered, so a file op that reads an
//          address written by the op just before sees the old value
`timescale 1ns/1ns

// Contract
// - add literal: acc plus k, flags C DC Z
// - and literal: acc and k, Z only
// - add file: acc plus file, C DC Z, one cycle
// - dest bit clear to acc, set to file
// - and file: result to dest, Z only
module aeu_core (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // instruction from fetch stage
   input  wire logic                          instr_valid_i,
   input  wire logic [aeu_pkg::IW-1:0]        instr_i,
   // register file read, same clock domain
   output logic      [aeu_pkg::AW-1:0]        file_raddr_o,
   input  wire logic [aeu_pkg::DW-1:0]        file_rdata_i,
   // register file write
   output logic                               file_we_o,
   output logic      [aeu_pkg::AW-1:0]        file_waddr_o,
   output logic      [aeu_pkg::DW-1:0]        file_wdata_o,
   // architectural state
   output logic      [aeu_pkg::DW-1:0]        acc_o,
   output logic                               carry_flag_o,
   output logic                               digit_carry_flag_o,
   output logic                               zero_flag_o
);
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   aeu_pkg::aeu_op_type    op;
   logic                   is_lit;
   logic                   is_file;
   logic                   is_add;
   logic                   to_file;
   logic [aeu_pkg::DW-1:0] opnd;
   logic [aeu_pkg::DW:0]   sum;
   logic [aeu_pkg::NW:0]   nib;
   logic [aeu_pkg::DW-1:0] res;
   logic                   res_zero;
   // architectural state and its next values
   logic [aeu_pkg::DW-1:0] acc_q;
   logic [aeu_pkg::DW-1:0] acc_d;
   logic                   carry_q;
   logic                   carry_d;
   logic                   dcarry_q;
   logic                   dcarry_d;
   logic                   zero_q;
   logic                   zero_d;
   // write-back stage
   logic                   we_q;
   logic [aeu_pkg::AW-1:0] waddr_q;
   logic [aeu_pkg::DW-1:0] wdata_q;

   // add literal is matched on one bit fewer, its low opcode bit is free
   always_comb begin
      op = aeu_pkg::AEU_OP_NONE;
      if (instr_valid_i) begin
         if (instr_i[aeu_pkg::OPC_MSB:aeu_pkg::ADD_LIT_LSB] == aeu_pkg::OP_ADD_LIT) begin
            op = aeu_pkg::AEU_OP_ADD_LIT;
         end else if (instr_i[aeu_pkg::OPC_MSB:aeu_pkg::OPC_LSB] == aeu_pkg::OP_AND_LIT) begin
            op = aeu_pkg::AEU_OP_AND_LIT;
         end else if (instr_i[aeu_pkg::OPC_MSB:aeu_pkg::OPC_LSB] == aeu_pkg::OP_ADD_FILE) begin
            op = aeu_pkg::AEU_OP_ADD_FILE;
         end else if (instr_i[aeu_pkg::OPC_MSB:aeu_pkg::OPC_LSB] == aeu_pkg::OP_AND_FILE) begin
            op = aeu_pkg::AEU_OP_AND_FILE;
         end
      end
   end

   // ------------------------------------------------------------
   // operation class
   // ------------------------------------------------------------
   always_comb begin
      is_lit  = 1'b0;
      is_file = 1'b0;
      is_add  = 1'b0;
      unique case (op)
         aeu_pkg::AEU_OP_ADD_LIT: begin
            is_lit = 1'b1;
            is_add = 1'b1;
         end
         aeu_pkg::AEU_OP_AND_LIT: begin
            is_lit = 1'b1;
         end
         aeu_pkg::AEU_OP_ADD_FILE: begin
            is_file = 1'b1;
            is_add  = 1'b1;
         end
         aeu_pkg::AEU_OP_AND_FILE: begin
            is_file = 1'b1;
         end
         aeu_pkg::AEU_OP_NONE: begin
            is_lit = 1'b0;
         end
         // three spare codes of the enum can never be decoded
         default: begin
            is_lit = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------
   // file address is always the low field so the file can read early;
   // left combinational because the file answers in the same cycle
   assign file_raddr_o = instr_i[aeu_pkg::AW-1:0];

   always_comb begin
      opnd     = is_lit ? instr_i[aeu_pkg::DW-1:0] : file_rdata_i;
      sum      = {1'b0, acc_q} + {1'b0, opnd};
      nib      = {1'b0, acc_q[aeu_pkg::NW-1:0]} + {1'b0, opnd[aeu_pkg::NW-1:0]};
      res      = is_add ? sum[aeu_pkg::DW-1:0] : (acc_q & opnd);
      res_zero = (res == aeu_pkg::ZERO_BYTE);
      to_file  = is_file && instr_i[aeu_pkg::DSEL_BIT];
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      acc_d = acc_q;
      if ((op != aeu_pkg::AEU_OP_NONE) && !to_file) begin
         acc_d = res;
      end
   end

   always_comb begin
      zero_d = zero_q;
      if (op != aeu_pkg::AEU_OP_NONE) begin
         zero_d = res_zero;
      end
   end

   // carries change only on additions; and ops leave them alone
   always_comb begin
      carry_d  = carry_q;
      dcarry_d = dcarry_q;
      if (is_add) begin
         carry_d  = sum[aeu_pkg::DW];
         dcarry_d = nib[aeu_pkg::NW];
      end
   end

   // ------------------------------------------------------------
   // accumulator
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_q <= aeu_pkg::ACC_RST;
      end else begin
         acc_q <= acc_d;
      end
   end

   // ------------------------------------------------------------
   // file write-back, registered one cycle after execute
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         we_q    <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
      end else begin
         we_q    <= to_file;
         waddr_q <= instr_i[aeu_pkg::AW-1:0];
         wdata_q <= res;
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         zero_q <= aeu_pkg::FLAG_RST;
      end else begin
         zero_q <= zero_d;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         carry_q  <= aeu_pkg::FLAG_RST;
         dcarry_q <= aeu_pkg::FLAG_RST;
      end else begin
         carry_q  <= carry_d;
         dcarry_q <= dcarry_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign acc_o              = acc_q;
   assign carry_flag_o       = carry_q;
   assign digit_carry_flag_o = dcarry_q;
   assign zero_flag_o        = zero_q;
   assign file_we_o          = we_q;
   assign file_waddr_o       = waddr_q;
   assign file_wdata_o       = wdata_q;
endmodule

// ---- hdl/aeu_pkg.sv ----
// Purpose: constants for the add and execute unit
// Assumes: 14-bit instruction words, 8-bit data
// Notes:   opcode patterns are compared on the upper instruction bits
package aeu_pkg;
   localparam int IW = 14;
   localparam int DW = 8;
   localparam int AW = 7;
   // ------------------------------------------------------------
   // opcode fields
   // ------------------------------------------------------------
   localparam int DSEL_BIT = 7;
   localparam int OPC_MSB = 13;
   localparam int ADD_LIT_LSB = 9;
   localparam int OPC_LSB = 8;
   localparam int NW = 4;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // literal ops: bits 13:9 for add (bit 8 free), bits 13:8 for and
   localparam logic [4:0] OP_ADD_LIT = 5'h1F;
   localparam logic [5:0] OP_AND_LIT = 6'h39;
   // file ops: bits 13:8
   localparam logic [5:0] OP_ADD_FILE = 6'h07;
   localparam logic [5:0] OP_AND_FILE = 6'h05;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic       FLAG_RST = 1'b0;
   typedef enum logic [2:0] {
      AEU_OP_NONE, AEU_OP_ADD_LIT, AEU_OP_AND_LIT, AEU_OP_ADD_FILE, AEU_OP_AND_FILE
   } aeu_op_type;
endpackage

// ---- verif/aeu_props.sv ----
// Purpose: port checks for aeu_core
// Assumes: write-back shows one cycle after issue
// Notes:   six relations, one per rule and one for the add carries
`timescale 1ns/1ns
module aeu_props (
   input wire logic        clk_i, rst_i, instr_valid_i,
   input wire logic        file_we_o, carry_flag_o,
   input wire logic        digit_carry_flag_o, zero_flag_o,
   input wire logic [13:0] instr_i,
   input wire logic [7:0]  file_rdata_i, file_wdata_o, acc_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire       v  = instr_valid_i;
   wire       al = v && instr_i[13:9] == aeu_pkg::OP_ADD_LIT;
   wire       nl = v && instr_i[13:8] == aeu_pkg::OP_AND_LIT;
   wire       af = v && instr_i[13:8] == aeu_pkg::OP_ADD_FILE;
   wire       nf = v && instr_i[13:8] == aeu_pkg::OP_AND_FILE;
   wire [7:0] y  = instr_i[13] ? instr_i[7:0] : file_rdata_i;
   wire [8:0] s  = acc_o + y;
   wire [4:0] h  = acc_o[3:0] + y[3:0];
   wire       co = s[8];
   wire       hc = h[4];
   wire [7:0] r  = (al || af) ? s[7:0] : acc_o & y;
   sequence wb_s;
      file_we_o && file_wdata_o == $past(r);
   endsequence
   a_add_lit: assert property (al |=> acc_o == $past(r)) else $error("add lit");
   a_and_lit: assert property (nl |=> acc_o == $past(r) && $stable(carry_flag_o))
      else $error("and lit");
   a_add_file: assert property (af && !instr_i[7] |=> acc_o == $past(r) && !file_we_o)
      else $error("add file");
   a_file_dest: assert property ((af || nf) && instr_i[7] |=> wb_s and $stable(acc_o))
      else $error("dest");
   a_and_file: assert property (nf |=> zero_flag_o == ($past(r) == 8'h00))
      else $error("and file");
   a_add_flags: assert property (al || af |=> carry_flag_o == $past(co)
      && digit_carry_flag_o == $past(hc)) else $error("flags");
endmodule

// ---- verif/aeu_regfile.sv ----
// Purpose: data register file partner
// Assumes: combinational read
// Notes:   no bypass: a write lands at the clock
`timescale 1ns/1ns
module aeu_regfile (
   input  wire logic       clk_i, we_i,
   input  wire logic [6:0] raddr_i, waddr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] rdata_o
);
   logic [7:0] mem [128];
   assign rdata_o = mem[raddr_i];
   always @(posedge clk_i) begin
      if (we_i) mem[waddr_i] <= wdata_i;
   end
endmodule

// ---- verif/aeu_core_tb.sv ----
// Purpose: random check of aeu_core against a model
// Assumes: file data from aeu_regfile
// Notes:   idles follow a write-back, the file has no bypass
`timescale 1ns/1ns
module aeu_core_tb;
   logic        clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0;
   logic        file_we_o, carry_flag_o, digit_carry_flag_o, zero_flag_o;
   logic [13:0] instr_i = 14'h0000;
   logic [6:0]  file_raddr_o, file_waddr_o;
   logic [7:0]  file_rdata_i, file_wdata_o, acc_o, acc = 8'h00, m [128];
   logic        c = 1'b0, dc = 1'b0, z = 1'b0;
   int          err_count = 0, n_tests = 0;
   aeu_core aeu_core_i (.*);
   aeu_regfile aeu_regfile_i (.clk_i, .we_i(file_we_o), .raddr_i(file_raddr_o),
      .waddr_i(file_waddr_o), .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
   initial forever #20 clk_i = ~clk_i;
   task chk(input logic ok);
      n_tests++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("mismatch at %0t: state differs", $time);
      end
   endtask
   task final_report;
      $display("errors %0d of %0d checks", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // op 4 is an unknown opcode, op 5 an idle cycle
   task automatic step(input int op, input logic d, input logic [7:0] k);
      logic [8:0] s;
      logic [7:0] y, r;
      y = (op < 2) ? k : m[k[6:0]];
      s = acc + y;
      r = op[0] ? acc & y : s[7:0];
      case (op)
         0: instr_i = {aeu_pkg::OP_ADD_LIT, d, k};
         1: instr_i = {aeu_pkg::OP_AND_LIT, k};
         2: instr_i = {aeu_pkg::OP_ADD_FILE, d, k[6:0]};
         3: instr_i = {aeu_pkg::OP_AND_FILE, d, k[6:0]};
         default: instr_i = {6'h00, d, k[6:0]};
      endcase
      instr_valid_i = op < 5;
      if (op < 4) begin
         if (!op[0]) {c, dc} = {s[8], acc[3:0] + y[3:0] > 5'h0F};
         z = r == 8'h00;
         if (op > 1 && d) m[k[6:0]] = r;
         else acc = r;
      end
      @(negedge clk_i);
      chk({acc_o, carry_flag_o, digit_carry_flag_o, zero_flag_o} === {acc, c, dc, z});
      if (op > 1 && op < 4 && d) chk({file_we_o, file_waddr_o, file_wdata_o} === {1'b1, k[6:0], r});
      else chk(file_we_o === 1'b0);
      if (op > 1 && op < 4 && d) begin
         instr_valid_i = 1'b0;
         repeat (2) @(negedge clk_i);
      end
   endtask
   initial begin
      void'($urandom(32'hdf5ed45d));
      for (int a = 0; a < 128; a++) begin
         m[a] = 8'($urandom);
         aeu_regfile_i.mem[a] = m[a];
      end
      repeat (8) @(negedge clk_i);
      chk(acc_o === 8'h00 && zero_flag_o === 1'b0 && file_we_o === 1'b0);
      rst_i = 1'b0;
      for (int i = 0; i < 2000; i++) step($urandom % 6, 1'($urandom), 8'($urandom));
      for (int a = 0; a < 128; a++) chk(aeu_regfile_i.mem[a] === m[a]);
      final_report();
   end
endmodule
bind aeu_core aeu_props aeu_props_i (.*);
